// ===== crf_addr_unit.sv
`default_nettype none
// forms a data-space address from the mode and pointer, and decodes its region
module crf_addr_unit (
   input wire crf_pkg::crf_mode_t mode,
   input wire logic [crf_pkg::ADDR_W-1:0] ptr_val,
   input wire logic [crf_pkg::DISP_W-1:0] disp,
   input wire logic [crf_pkg::ADDR_W-1:0] daddr,
   input wire logic [crf_pkg::IO_AW-1:0] io_addr,
   output logic [crf_pkg::ADDR_W-1:0] eff_addr,
   output logic [crf_pkg::ADDR_W-1:0] ptr_new,
   output logic ptr_upd,
   output crf_pkg::crf_region_t region
);
   // pointer arithmetic kept at 16 bits, wraps silently
   wire [crf_pkg::ADDR_W-1:0] ptr_dec = ptr_val - 16'h0001;
   wire [crf_pkg::ADDR_W-1:0] ptr_inc = ptr_val + 16'h0001;
   wire [crf_pkg::ADDR_W-1:0] disp_ext = {{(crf_pkg::ADDR_W - crf_pkg::DISP_W){1'b0}}, disp};
   wire [crf_pkg::ADDR_W-1:0] io_ext = {{(crf_pkg::ADDR_W - crf_pkg::IO_AW){1'b0}}, io_addr};

   // address selection per mode
   always_comb begin
      eff_addr = daddr;
      ptr_new = ptr_val;
      ptr_upd = 1'b0;
      case (mode)
         crf_pkg::AM_DIRECT: eff_addr = daddr;
         crf_pkg::AM_DISP: eff_addr = ptr_val + disp_ext;
         crf_pkg::AM_IND: eff_addr = ptr_val;
         crf_pkg::AM_PREDEC: begin
            eff_addr = ptr_dec;
            ptr_new = ptr_dec;
            ptr_upd = 1'b1;
         end
         crf_pkg::AM_POSTINC: begin
            eff_addr = ptr_val;
            ptr_new = ptr_inc;
            ptr_upd = 1'b1;
         end
         crf_pkg::AM_IO: eff_addr = io_ext + crf_pkg::IO_BASE;
         default: eff_addr = daddr;
      endcase
   end

   // region decode; anything above sram has no storage here
   wire in_reg = eff_addr < crf_pkg::IO_BASE;
   wire in_io = !in_reg && (eff_addr < crf_pkg::SRAM_BASE);
   wire in_sram = (eff_addr >= crf_pkg::SRAM_BASE) && (eff_addr <= crf_pkg::SRAM_END);
   assign region = in_reg ? crf_pkg::RG_REG : in_io ? crf_pkg::RG_IO : in_sram ? crf_pkg::RG_SRAM
      : crf_pkg::RG_NONE;
endmodule : crf_addr_unit
`default_nettype wire

// ===== crf_core.sv
`default_nettype none
module crf_core #(
   parameter int unsigned PC_W = 11
) (
   input wire logic core_clk,
   input wire logic rst_n,
   // decoded operation and its alu result path
   input wire crf_pkg::crf_op_t op,
   input wire logic op_valid,
   input wire logic [3:0] alu_sel,
   // program memory
   input wire logic [crf_pkg::PW_W-1:0] pmem_rdata,
   output logic [PC_W-1:0] pmem_addr,
   output logic [crf_pkg::PW_W-1:0] instr_word,
   output logic instr_valid,
   input wire logic stall,
   // jump/call control and constant lookup
   input wire logic call_req,
   input wire logic [PC_W-1:0] call_target,
   input wire logic lpm_req,
   output logic [crf_pkg::PW_W-1:0] lpm_word_addr,
   output logic lpm_high_byte,
   // external data-space access (I/O and sram)
   output crf_pkg::crf_bus_t dbus,
   input wire logic [crf_pkg::DATA_W-1:0] dbus_rdata,
   // interrupts
   input wire logic [crf_pkg::IRQ_N-1:0] irq_req,
   input wire logic global_int_en,
   output logic irq_taken,
   output logic [crf_pkg::IRQ_IW-1:0] irq_vector,
   // observed state
   output logic [crf_pkg::SP_W-1:0] stack_pointer,
   output logic [crf_pkg::DATA_W-1:0] alu_result,
   output logic imm_reject
);
   // zero padding that widens the return address to a data-space word
   // for the byte split of the push
   localparam int unsigned PC_PAD = crf_pkg::ADDR_W - PC_W;

   // register storage
   // every word has a write process of its own in the generate loop below,
   // so no element of the array ever sees two drivers
   logic [crf_pkg::DATA_W-1:0] regs_reg [crf_pkg::REG_COUNT];
   logic [PC_W-1:0] program_counter_reg; // fetch address
   // fetched word and its flag, handed to the decoder outside
   logic [crf_pkg::PW_W-1:0] instr_reg;
   logic instr_valid_reg;
   logic [crf_pkg::SP_W-1:0] sp_reg;
   logic [crf_pkg::DATA_W-1:0] result_reg;
   logic imm_reject_reg;
   logic irq_taken_reg;
   logic [crf_pkg::IRQ_IW-1:0] irq_vec_reg;
   crf_pkg::crf_bus_t dbus_reg;

   // push sequencer: low then high byte of return address
   typedef enum logic [2:0] {PS_IDLE = 3'h1, PS_LOW = 3'h2, PS_HIGH = 3'h4} crf_push_t;
   crf_push_t push_reg, push_next;
   logic [PC_W-1:0] ret_pc_reg;

   // operand reads, both ports in the same cycle
   // the reads are combinational so the alu result can land at the same edge
   wire [crf_pkg::DATA_W-1:0] dst_operand = regs_reg[op.dst];
   wire [crf_pkg::DATA_W-1:0] source_operand_reg = regs_reg[op.src];
   wire [crf_pkg::DATA_W-1:0] b_operand = op.imm_op ? op.imm : source_operand_reg;

   // immediate forms only reach the upper half
   wire imm_bad = op.imm_op && (op.dst < crf_pkg::IMM_REG_MIN);
   wire alu_go = op_valid && op.alu_en && !imm_bad && !stall;

   // small alu: result written to destination
   // only a handful of functions; flags and carries live outside this block
   logic [crf_pkg::DATA_W-1:0] alu_out;
   always_comb begin
      case (alu_sel)
         4'h0: alu_out = dst_operand + b_operand;
         4'h1: alu_out = dst_operand - b_operand;
         4'h2: alu_out = dst_operand & b_operand;
         4'h3: alu_out = dst_operand | b_operand;
         4'h4: alu_out = dst_operand ^ b_operand;
         4'h5: alu_out = b_operand;
         4'h6: alu_out = ~dst_operand;
         4'h7: alu_out = dst_operand + 8'h01;
         4'h8: alu_out = dst_operand - 8'h01;
         default: alu_out = dst_operand;
      endcase
   end

   // pointer selection: low byte even register, high byte odd
   // the high index is the low one with bit 0 set
   wire [crf_pkg::REG_AW-1:0] ptr_lo_idx = (op.ptr == crf_pkg::PTR_X) ? crf_pkg::PTR_X_LO
      : (op.ptr == crf_pkg::PTR_Y) ? crf_pkg::PTR_Y_LO : crf_pkg::PTR_Z_LO;
   wire [crf_pkg::REG_AW-1:0] ptr_hi_idx = ptr_lo_idx | 5'h01;
   wire [crf_pkg::ADDR_W-1:0] ptr_val = {regs_reg[ptr_hi_idx], regs_reg[ptr_lo_idx]};
   wire [crf_pkg::ADDR_W-1:0] z_val = {regs_reg[crf_pkg::PTR_Z_LO | 5'h01], regs_reg[crf_pkg::PTR_Z_LO]};

   // constant lookup: upper bits select the word, bit 0 the byte
   assign lpm_word_addr = {1'b0, z_val[crf_pkg::ADDR_W-1:1]};
   assign lpm_high_byte = z_val[0];

   // address formation
   wire [crf_pkg::ADDR_W-1:0] eff_addr;
   wire [crf_pkg::ADDR_W-1:0] ptr_new;
   wire ptr_upd;
   crf_pkg::crf_region_t region;
   crf_addr_unit u_addr (
      .mode(op.mode),
      .ptr_val(ptr_val),
      .disp(op.disp),
      .daddr(op.daddr),
      .io_addr(op.io_addr),
      .eff_addr(eff_addr),
      .ptr_new(ptr_new),
      .ptr_upd(ptr_upd),
      .region(region)
   );

   // a data access is split three ways: register hits stay inside, the stack
   // pointer is answered locally, and only io and sram reach the outward bus
   wire mem_go = op_valid && op.mem_en && !stall;
   wire mem_reg = mem_go && (region == crf_pkg::RG_REG);
   wire [crf_pkg::REG_AW-1:0] mem_reg_idx = eff_addr[crf_pkg::REG_AW-1:0];
   wire mem_ext = mem_go && (region == crf_pkg::RG_IO || region == crf_pkg::RG_SRAM);
   wire [crf_pkg::IO_AW-1:0] io_off = eff_addr[crf_pkg::IO_AW-1:0] - crf_pkg::IO_BASE[crf_pkg::IO_AW-1:0];
   // stack pointer is served internally in I/O space
   wire sp_hit = mem_go && (region == crf_pkg::RG_IO) && (io_off == crf_pkg::SP_IO_ADDR);
   wire sp_sw_wr = sp_hit && op.mem_wr;
   wire pushing = (push_reg != PS_IDLE);
   wire [crf_pkg::ADDR_W-1:0] ret_pc_ext = {{PC_PAD{1'b0}}, ret_pc_reg};

   // loads land in the register named by the destination field
   wire [crf_pkg::DATA_W-1:0] load_data = mem_reg ? regs_reg[mem_reg_idx] : sp_hit ? sp_reg : dbus_rdata;

   // register write ports: alu result, load result, store to a register address, pointer update
   genvar gi;
   generate
      for (gi = 0; gi < crf_pkg::REG_COUNT; gi++) begin : g_reg
         wire [crf_pkg::REG_AW-1:0] idx = crf_pkg::REG_AW'(gi);
         wire alu_wr = alu_go && (op.dst == idx);
         wire st_wr = mem_reg && op.mem_wr && (mem_reg_idx == idx);
         wire ld_wr = mem_go && !op.mem_wr && (op.dst == idx);
         wire plo_wr = mem_go && ptr_upd && (ptr_lo_idx == idx);
         wire phi_wr = mem_go && ptr_upd && (ptr_hi_idx == idx);
         // register update; pointer writeback after the data transfer wins
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               regs_reg[gi] <= 8'h00;
            end else if (plo_wr) begin
               regs_reg[gi] <= ptr_new[crf_pkg::DATA_W-1:0];
            end else if (phi_wr) begin
               regs_reg[gi] <= ptr_new[crf_pkg::ADDR_W-1:crf_pkg::DATA_W];
            end else if (ld_wr) begin
               regs_reg[gi] <= load_data;
            end else if (st_wr) begin
               regs_reg[gi] <= dst_operand;
            end else if (alu_wr) begin
               regs_reg[gi] <= alu_out;
            end
         end
      end
   endgenerate

   // interrupt priority: lowest index wins
   // scanning from the top down lets the lowest pending request write last
   logic [crf_pkg::IRQ_IW-1:0] irq_sel;
   logic irq_any;
   always_comb begin
      irq_sel = 4'h0;
      irq_any = 1'b0;
      for (int i = crf_pkg::IRQ_N - 1; i >= 0; i--) begin
         if (irq_req[i]) begin
            irq_sel = i[crf_pkg::IRQ_IW-1:0];
            irq_any = 1'b1;
         end
      end
   end
   // a stall freezes the fetch counter unless a call arrives, and an interrupt is held off until it
   // lifts; a call in the same cycle goes first and the request waits
   wire irq_go = irq_any && global_int_en && !pushing && !call_req && !stall;

   // push sequencing
   // two bytes per push; calls and interrupts seen meanwhile are ignored,
   // so a requester must keep its request up until the sequencer is idle
   always_comb begin
      case (push_reg)
         PS_IDLE: push_next = (irq_go || call_req) ? PS_LOW : PS_IDLE;
         PS_LOW: push_next = PS_HIGH;
         PS_HIGH: push_next = PS_IDLE;
         default: push_next = PS_IDLE;
      endcase
   end

   // fetch pipeline: next word fetched while current executes
   // a redirect drops the prefetched word; the flag stays low until the push ends
   wire fetch_en = !stall && !pushing;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         program_counter_reg <= '0;
         instr_reg <= 16'h0000;
         instr_valid_reg <= 1'b0;
      end else if (irq_go) begin
         program_counter_reg <= {{(PC_W - crf_pkg::IRQ_IW){1'b0}}, irq_sel};
         instr_valid_reg <= 1'b0;
      end else if (call_req && !pushing) begin
         program_counter_reg <= call_target;
         instr_valid_reg <= 1'b0;
      end else if (fetch_en) begin
         instr_reg <= pmem_rdata;
         instr_valid_reg <= 1'b1;
         program_counter_reg <= program_counter_reg + 1'b1;
      end
   end

   // return address capture and push bookkeeping
   // the stack pointer counts down one byte per pushed byte
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         push_reg <= PS_IDLE;
         ret_pc_reg <= '0;
         sp_reg <= crf_pkg::SP_RESET;
      end else begin
         push_reg <= push_next;
         if (!pushing && (irq_go || call_req)) begin
            ret_pc_reg <= program_counter_reg;
         end
         if (pushing) begin
            sp_reg <= sp_reg - 8'h01;
         end else if (sp_sw_wr) begin
            sp_reg <= dst_operand;
         end
      end
   end

   // outward access: push has priority, else forwarded io/sram access
   // limitation: a data access issued during a push is not forwarded
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dbus_reg <= '0;
      end else if (pushing) begin
         dbus_reg.valid <= 1'b1;
         dbus_reg.wr <= 1'b1;
         dbus_reg.region <= crf_pkg::RG_SRAM;
         dbus_reg.addr <= {8'h00, sp_reg};
         dbus_reg.wdata <= (push_reg == PS_LOW) ? ret_pc_ext[7:0] : ret_pc_ext[15:8];
      end else begin
         dbus_reg.valid <= mem_ext && !sp_hit;
         dbus_reg.wr <= op.mem_wr;
         dbus_reg.region <= region;
         dbus_reg.addr <= eff_addr;
         dbus_reg.wdata <= dst_operand;
      end
   end

   // status outputs
   // one-cycle pulses, except the alu result and the interrupt vector, which stand until replaced
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         result_reg <= 8'h00;
         imm_reject_reg <= 1'b0;
         irq_taken_reg <= 1'b0;
         irq_vec_reg <= 4'h0;
      end else begin
         if (alu_go) result_reg <= alu_out;
         imm_reject_reg <= op_valid && op.alu_en && imm_bad;
         irq_taken_reg <= irq_go;
         if (irq_go) irq_vec_reg <= irq_sel;
      end
   end

   // every output below comes straight from a flip-flop
   assign pmem_addr = program_counter_reg;
   assign instr_word = instr_reg;
   assign instr_valid = instr_valid_reg;
   assign dbus = dbus_reg;
   assign stack_pointer = sp_reg;
   assign alu_result = result_reg;
   assign imm_reject = imm_reject_reg;
   assign irq_taken = irq_taken_reg;
   assign irq_vector = irq_vec_reg;
endmodule : crf_core
`default_nettype wire

// ===== crf_core_chk.sv
`default_nettype none
// port-level relations of the core: data map, fetch pacing, interrupt gating
module crf_core_chk #(
   parameter int unsigned PC_W = 11
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire crf_pkg::crf_op_t op,
   input wire logic op_valid,
   input wire logic stall,
   input wire logic [3:0] alu_sel,
   input wire logic call_req,
   input wire logic [crf_pkg::IRQ_N-1:0] irq_req,
   input wire logic global_int_en,
   input wire logic [PC_W-1:0] pmem_addr,
   input wire crf_pkg::crf_bus_t dbus,
   input wire logic irq_taken,
   input wire logic [crf_pkg::PW_W-1:0] lpm_word_addr,
   input wire logic imm_reject
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // io pulses must stay in the io window
   io_window_a: assert property (dbus.valid && dbus.region == crf_pkg::RG_IO |-> dbus.addr inside {[16'h0020:16'h005F]})
      else $error("io access outside its window");
   sram_window_a: assert property (dbus.valid && dbus.region == crf_pkg::RG_SRAM |-> dbus.addr inside {[16'h0060:16'h00DF]})
      else $error("sram access outside its window");
   // register and unmapped addresses never leave the core
   bus_region_a: assert property (dbus.valid |-> dbus.region inside {crf_pkg::RG_IO, crf_pkg::RG_SRAM})
      else $error("bus pulse for a register or unmapped address");
   irq_gate_a: assert property (irq_taken |-> $past(global_int_en))
      else $error("interrupt taken while disabled");
   // an immediate move into the third pointer's low byte shows up shifted in the word address
   lpm_shift_a: assert property (op_valid && !stall && op.alu_en && op.imm_op && !op.mem_en && alu_sel == 4'h5
      && op.dst == crf_pkg::PTR_Z_LO |=> !lpm_word_addr[15]
      && {1'b0, lpm_word_addr[6:0]} == ($past(op.imm) >> 1))
      else $error("constant word address not shifted");
   // quiet fetch advances one word a cycle, wrapping at the counter width
   pc_step_a: assert property ((!stall && !call_req && irq_req == 16'h0000 && !irq_taken)[*4] |=> pmem_addr == PC_W'($past(pmem_addr) + 1))
      else $error("fetch did not advance by one");
   stall_hold_a: assert property (stall && !call_req |=> $stable(pmem_addr))
      else $error("fetch moved under stall");
   imm_reject_a: assert property (op_valid && !stall && op.alu_en && op.imm_op && op.dst < crf_pkg::IMM_REG_MIN |=> imm_reject)
      else $error("low register immediate not refused");
   imm_accept_a: assert property (op_valid && !stall && op.imm_op && op.dst >= crf_pkg::IMM_REG_MIN |=> !imm_reject)
      else $error("upper register immediate refused");
endmodule // crf_core_chk
bind crf_core crf_core_chk #(.PC_W(PC_W)) chk (.core_clk(core_clk), .rst_n(rst_n), .op(op), .op_valid(op_valid),
   .stall(stall), .call_req(call_req), .irq_req(irq_req), .global_int_en(global_int_en), .pmem_addr(pmem_addr),
   .dbus(dbus), .irq_taken(irq_taken), .lpm_word_addr(lpm_word_addr), .imm_reject(imm_reject), .alu_sel(alu_sel));
`default_nettype wire

// ===== crf_core_tb.sv
`default_nettype none
module crf_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst_n, op_valid, stall, call_req, global_int_en, lpm_req;
   crf_pkg::crf_op_t op;
   crf_pkg::crf_bus_t dbus, seen;
   logic [3:0] alu_sel, irq_vector;
   logic [15:0] pmem_rdata, instr_word, lpm_word_addr, irq_req;
   logic [9:0] pmem_addr, call_target, a;
   logic instr_valid, lpm_high_byte, irq_taken, imm_reject, seen_rej;
   logic [7:0] dbus_rdata, load_val, stack_pointer, alu_result, seen_res, n;
   int failures, total_checks, k;
   // small variant keeps the program counter at 10 bits
   crf_core #(.PC_W(10)) dut (.core_clk(core_clk), .rst_n(rst_n), .op(op), .op_valid(op_valid), .alu_sel(alu_sel),
      .pmem_rdata(pmem_rdata), .pmem_addr(pmem_addr), .instr_word(instr_word), .instr_valid(instr_valid),
      .stall(stall), .call_req(call_req), .call_target(call_target), .lpm_req(lpm_req),
      .lpm_word_addr(lpm_word_addr), .lpm_high_byte(lpm_high_byte), .dbus(dbus), .dbus_rdata(dbus_rdata),
      .irq_req(irq_req), .global_int_en(global_int_en), .irq_taken(irq_taken), .irq_vector(irq_vector),
      .stack_pointer(stack_pointer), .alu_result(alu_result), .imm_reject(imm_reject));
   crf_mem_model #(.PC_W(10)) p (.core_clk(core_clk), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
      .dbus(dbus), .load_val(load_val), .dbus_rdata(dbus_rdata));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task check(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task conclude;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // mode codes: 0 direct, 1 disp, 2 plain, 3 predec, 4 postinc, 5 io
   function automatic crf_pkg::crf_op_t mk(logic al, logic im, logic [4:0] d, logic [4:0] s, logic [7:0] v,
      logic me, logic wr, logic [2:0] m, logic [1:0] pt, logic [5:0] ds, logic [15:0] da, logic [5:0] io);
      mk = '{al, im, d, s, v, me, wr, crf_pkg::crf_mode_t'(m), crf_pkg::crf_ptr_t'(pt), ds, da, io};
   endfunction
   // one op per two cycles; outputs captured right after the taking edge
   task exec(input crf_pkg::crf_op_t o, input logic [3:0] sel);
      op = o;
      alu_sel = sel;
      op_valid = 1'b1;
      @(posedge core_clk); #1;
      op_valid = 1'b0;
      seen = dbus;
      seen_res = alu_result;
      seen_rej = imm_reject;
      @(posedge core_clk); #1;
   endtask
   task ldi(input logic [4:0] d, input logic [7:0] v);
      exec(mk(1, 1, d, 0, v, 0, 0, 0, 0, 0, 0, 0), 4'h5);
   endtask
   task mem(input logic wr, input logic [2:0] m, input logic [1:0] pt, input logic [5:0] ds,
      input logic [15:0] da, input logic [5:0] io, input logic [4:0] d);
      exec(mk(0, 0, d, 0, 0, 1, wr, m, pt, ds, da, io), 4'h0);
   endtask
   task t_imm;
      ldi(5'h0F, 8'h11);
      check(seen_rej, 1'b1);
      ldi(5'h10, 8'h05);
      check(seen_rej, 1'b0);
      check(seen_res, 8'h05);
   endtask
   task t_alu;
      ldi(5'h11, 8'h03);
      exec(mk(1, 0, 5'h02, 5'h10, 0, 0, 0, 0, 0, 0, 0, 0), 4'h5);
      check(seen_res, 8'h05);
      exec(mk(1, 0, 5'h02, 5'h11, 0, 0, 0, 0, 0, 0, 0, 0), 4'h0);
      check(seen_res, 8'h08);
      mem(1, 0, 0, 0, 16'h0060, 0, 5'h02);
      check(seen.addr, 16'h0060);
      check(seen.wdata, 8'h08);
      // a load from a register address copies the register, off the bus
      mem(0, 0, 0, 0, 16'h0002, 0, 5'h05);
      check(seen.valid, 1'b0);
      mem(1, 0, 0, 0, 16'h0061, 0, 5'h05);
      check(seen.wdata, 8'h08);
      // an sram load takes the partner's read data into the destination
      mem(0, 0, 0, 0, 16'h0062, 0, 5'h06);
      check(seen.wr, 1'b0);
      mem(1, 0, 0, 0, 16'h0063, 0, 5'h06);
      check(seen.wdata, 8'hA5);
   endtask
   task t_ptr;
      ldi(5'h1A, 8'h60);
      ldi(5'h1B, 8'h00);
      mem(1, 4, 0, 0, 0, 0, 5'h02);
      check(seen.addr, 16'h0060);
      mem(1, 2, 0, 0, 0, 0, 5'h02);
      check(seen.addr, 16'h0061);
      mem(1, 3, 0, 0, 0, 0, 5'h02);
      check(seen.addr, 16'h0060);
      mem(1, 2, 0, 0, 0, 0, 5'h02);
      check(seen.addr, 16'h0060);
      ldi(5'h1C, 8'h70);
      ldi(5'h1D, 8'h00);
      mem(1, 1, 1, 6'h3F, 0, 0, 5'h02);
      check(seen.addr, 16'h00AF);
      // high byte moves the pointer out of the map: no pulse
      ldi(5'h1B, 8'h01);
      mem(1, 2, 0, 0, 0, 0, 5'h02);
      check(seen.valid, 1'b0);
   endtask
   task t_map;
      logic [15:0] ad [6];
      logic [3:0] rg [6];
      ad = '{16'h0010, 16'h0020, 16'h005F, 16'h0060, 16'h00DF, 16'h00E0};
      rg = '{4'h8, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8};
      for (int i = 0; i < 6; i++) begin
         mem(1, 0, 0, 0, ad[i], 0, 5'h02);
         check(seen.valid, 1'(rg[i] != 4'h8));
         if (seen.valid === 1'b1) check(seen.region, rg[i]);
      end
      mem(1, 5, 0, 0, 0, 6'h05, 5'h02);
      check(seen.region, crf_pkg::RG_IO);
   endtask
   task t_lpm;
      ldi(5'h1E, 8'h35);
      ldi(5'h1F, 8'h01);
      check(lpm_word_addr, 16'h009A);
      check(lpm_high_byte, 1'b1);
   endtask
   task t_stack;
      ldi(5'h12, 8'hDF);
      mem(1, 5, 0, 0, 0, 6'h3D, 5'h12);
      check(seen.valid, 1'b0);
      check(stack_pointer, 8'hDF);
      n = p.wr_count;
      irq_req = 16'h0028;
      repeat (4) begin
         @(posedge core_clk); #1;
         check(irq_taken, 1'b0);
      end
      global_int_en = 1'b1;
      for (k = 0; k < 20 && irq_taken !== 1'b1; k++) @(posedge core_clk) #1;
      check(irq_taken, 1'b1);
      check(irq_vector, 4'h3);
      irq_req = 16'h0000;
      global_int_en = 1'b0;
      repeat (4) @(posedge core_clk) #1;
      check(stack_pointer, 8'hDD);
      check(8'(p.wr_count - n), 8'h02);
      check(p.last_addr, 16'h00DE);
      call_target = 10'h3FE;
      call_req = 1'b1;
      @(posedge core_clk); #1;
      call_req = 1'b0;
      for (k = 0; k < 10 && pmem_addr !== 10'h3FE; k++) @(posedge core_clk) #1;
      check(pmem_addr, 10'h3FE);
      repeat (6) @(posedge core_clk) #1;
      check(stack_pointer, 8'hDB);
   endtask
   task t_fetch;
      stall = 1'b1;
      @(posedge core_clk); #1;
      a = pmem_addr;
      repeat (3) @(posedge core_clk) #1;
      check(pmem_addr, a);
      stall = 1'b0;
      @(posedge core_clk); #1;
      a = pmem_addr;
      @(posedge core_clk); #1;
      check(instr_valid, 1'b1);
      check(instr_word, {5'h15, 1'b0, a});
      check(pmem_addr, a + 10'h001);
   endtask
   initial begin
      rst_n = 1'b0;
      op_valid = 1'b0;
      op = '0;
      alu_sel = 4'h0;
      stall = 1'b0;
      call_req = 1'b0;
      call_target = 10'h000;
      lpm_req = 1'b0;
      irq_req = 16'h0000;
      global_int_en = 1'b0;
      load_val = 8'hA5;
      failures = 0;
      total_checks = 0;
      repeat (2) @(posedge core_clk);
      #1 rst_n = 1'b1;
      check(stack_pointer, crf_pkg::SP_RESET);
      t_imm;
      t_alu;
      t_ptr;
      t_map;
      t_lpm;
      t_stack;
      t_fetch;
      conclude;
   end
   // the whole sequence needs under a hundred cycles
   initial begin
      #200000;
      failures++;
      conclude;
   end
endmodule // crf_core_tb
`default_nettype wire

// ===== crf_mem_model.sv
`default_nettype none
// program memory and data-side recorder facing the core
module crf_mem_model #(
   parameter int unsigned PC_W = 11
) (
   input wire logic core_clk,
   input wire logic [PC_W-1:0] pmem_addr,
   output logic [crf_pkg::PW_W-1:0] pmem_rdata,
   input wire crf_pkg::crf_bus_t dbus,
   input wire logic [crf_pkg::DATA_W-1:0] load_val,
   output logic [crf_pkg::DATA_W-1:0] dbus_rdata
);
   logic [7:0] wr_count; // writes seen on the bus
   logic [15:0] last_addr; // address of the latest write
   // a tag over the address lets the bench predict every fetched word
   assign pmem_rdata = {5'h15, 11'(pmem_addr)};
   assign dbus_rdata = load_val;
   initial wr_count = 8'h00;
   // record writes; the stack push shows up here as two bytes
   always @(posedge core_clk) begin
      if (dbus.valid && dbus.wr) begin
         wr_count <= wr_count + 8'h01;
         last_addr <= dbus.addr;
      end
   end
endmodule // crf_mem_model
`default_nettype wire

// ===== crf_pkg.sv
`default_nettype none
package crf_pkg;
   // register file geometry and other field widths
   localparam int unsigned REG_COUNT = 32;
   localparam int unsigned REG_AW = 5;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned IO_AW = 6;
   localparam int unsigned DISP_W = 6;
   localparam int unsigned SP_W = 8;
   localparam int unsigned PC_W_MAX = 11;
   localparam int unsigned PW_W = 16;
   localparam int unsigned IRQ_N = 16;
   localparam int unsigned IRQ_IW = 4;
   // lowest register usable by immediate-operand operations
   localparam logic [REG_AW-1:0] IMM_REG_MIN = 5'h10;
   // pointer low-byte register indices (high byte is the next odd one)
   localparam logic [REG_AW-1:0] PTR_X_LO = 5'h1A;
   localparam logic [REG_AW-1:0] PTR_Y_LO = 5'h1C;
   localparam logic [REG_AW-1:0] PTR_Z_LO = 5'h1E;
   // data space map
   localparam logic [ADDR_W-1:0] IO_BASE = 16'h0020;
   localparam logic [ADDR_W-1:0] SRAM_BASE = 16'h0060;
   localparam logic [ADDR_W-1:0] SRAM_END = 16'h00DF;
   // stack pointer reset value and I/O location
   localparam logic [SP_W-1:0] SP_RESET = 8'h00;
   localparam logic [IO_AW-1:0] SP_IO_ADDR = 6'h3D;
   // pointer select
   typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} crf_ptr_t;
   // addressing modes of a data access
   typedef enum logic [2:0] {
      AM_DIRECT = 3'h0, AM_DISP = 3'h1, AM_IND = 3'h2, AM_PREDEC = 3'h3, AM_POSTINC = 3'h4, AM_IO = 3'h5
   } crf_mode_t;
   // decoded data-space region
   typedef enum logic [3:0] {
      RG_REG = 4'h1, RG_IO = 4'h2, RG_SRAM = 4'h4, RG_NONE = 4'h8
   } crf_region_t;
   // one executed operation, as presented by the decoder
   typedef struct packed {
      logic alu_en;
      logic imm_op;
      logic [REG_AW-1:0] dst;
      logic [REG_AW-1:0] src;
      logic [DATA_W-1:0] imm;
      logic mem_en;
      logic mem_wr;
      crf_mode_t mode;
      crf_ptr_t ptr;
      logic [DISP_W-1:0] disp;
      logic [ADDR_W-1:0] daddr;
      logic [IO_AW-1:0] io_addr;
   } crf_op_t;
   // outward data-space access
   typedef struct packed {
      logic valid;
      logic wr;
      crf_region_t region;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } crf_bus_t;
endpackage : crf_pkg
`default_nettype wire
